// ---- rtl/aod_pkg.sv ----
// Constants, encodings and carrier types for the arithmetic opcode decoder
package aod_pkg;
    // Opcode match masks and values
    localparam logic [7:0] PFX_MASK = 8'he7;
    localparam logic [7:0] PFX_VAL = 8'h26;
    localparam logic [7:0] RM_MASK = 8'hfc;
    localparam logic [7:0] W_MASK = 8'hfe;
    localparam logic [7:0] ADC_RM = 8'h10;
    localparam logic [7:0] ADC_ACC = 8'h14;
    localparam logic [7:0] SBB_RM = 8'h18;
    localparam logic [7:0] SBB_ACC = 8'h1c;
    localparam logic [7:0] GRP_IMM = 8'h80;
    localparam logic [7:0] GRP_UNARY = 8'hf6;
    localparam logic [7:0] OPC_AAA = 8'h37;
    localparam logic [7:0] OPC_DAA = 8'h27;
    localparam logic [7:0] OPC_AAS = 8'h3f;
    localparam logic [7:0] OPC_DAS = 8'h2f;
    // Middle field of the ModRM byte inside the groups
    localparam logic [2:0] REG_ADC = 3'h2;
    localparam logic [2:0] REG_SBB = 3'h3;
    localparam logic [2:0] REG_NEG = 3'h3;
    localparam logic [2:0] REG_MUL = 3'h4;
    // Mode field and the direct-address case
    localparam logic [1:0] MOD_NODISP = 2'h0;
    localparam logic [1:0] MOD_D8 = 2'h1;
    localparam logic [1:0] MOD_D16 = 2'h2;
    localparam logic [1:0] MOD_REG = 2'h3;
    localparam logic [2:0] RM_DIRECT = 3'h6;
    // Execution clock counts
    localparam logic [2:0] PFX_CLOCKS = 3'h2;
    localparam logic [2:0] PFX_CAP = 3'h4;
    localparam logic [6:0] C_WORD_MEM = 7'h04;
    localparam logic [6:0] C_RM_REG = 7'h03;
    localparam logic [6:0] C_RM_MEM = 7'h0a;
    localparam logic [6:0] C_IMM_REG = 7'h04;
    localparam logic [6:0] C_IMM_MEM = 7'h10;
    localparam logic [6:0] C_ACC_B = 7'h03;
    localparam logic [6:0] C_ACC_W = 7'h04;
    localparam logic [6:0] C_NEG_REG = 7'h03;
    localparam logic [6:0] C_NEG_MEM = 7'h0a;
    localparam logic [6:0] C_AAA = 7'h08;
    localparam logic [6:0] C_DAA = 7'h07;
    localparam logic [6:0] C_AAS = 7'h07;
    localparam logic [6:0] C_DAS = 7'h04;
    localparam logic [6:0] C_MUL_RB_MIN = 7'h1a;
    localparam logic [6:0] C_MUL_RB_MAX = 7'h1c;
    localparam logic [6:0] C_MUL_RW_MIN = 7'h23;
    localparam logic [6:0] C_MUL_RW_MAX = 7'h25;
    localparam logic [6:0] C_MUL_MB_MIN = 7'h20;
    localparam logic [6:0] C_MUL_MB_MAX = 7'h22;
    localparam logic [6:0] C_MUL_MW_MIN = 7'h29;
    localparam logic [6:0] C_MUL_MW_MAX = 7'h2b;

    typedef enum logic [3:0] {
        op_none, add_with_carry, sub_with_borrow_op, sign_change_op, ascii_fix_after_add,
        decimal_fix_after_add, ascii_fix_after_sub, decimal_fix_after_sub, unsigned_multiply_op
    } aod_kind_t;
    typedef enum logic [2:0] {form_none, form_rm, form_imm, form_acc, form_unary} aod_form_t;
    typedef enum logic [1:0] {extra_segment, code_segment, stack_segment, data_segment} aod_seg_t;
    typedef enum logic [2:0] {
        st_opc = 3'h0, st_modrm = 3'h1, st_disp_lo = 3'h3, st_disp_hi = 3'h2, st_imm_lo = 3'h6, st_imm_hi = 3'h7
    } aod_state_t;

    typedef struct packed {
        logic word;
        logic [2:0] idx;
        logic high;
    } aod_reg_t;

    typedef struct packed {
        aod_kind_t kind;
        aod_form_t form;
        logic word;
        logic dir_to_reg;
        logic sx;
        logic seg_ovr_valid;
        aod_seg_t seg;
        logic [2:0] pfx_clocks;
        logic [1:0] mode;
        logic [2:0] reg_fld;
        logic [2:0] rm_fld;
        logic is_mem;
        aod_reg_t reg_sel;
        aod_reg_t rm_sel;
        logic [15:0] disp;
        logic [15:0] imm;
        logic [6:0] clk_min;
        logic [6:0] clk_max;
    } aod_op_t;

    typedef struct packed {
        aod_state_t st;
        aod_op_t w;
        aod_op_t o;
        logic op_valid;
        logic unsup;
        logic [1:0] disp_n;
        logic [1:0] imm_n;
    } aod_core_t;
endpackage

// ---- rtl/aod_field_map.sv ----
// ModRM field mapping: register selects, memory flag and displacement length
`timescale 1ns/1ps
module aod_field_map (
    // ModRM byte and width bit
    input wire logic [7:0] modrm_i,
    input wire logic word_i,
    // Decoded fields
    output aod_pkg::aod_reg_t reg_sel_o,
    output aod_pkg::aod_reg_t rm_sel_o,
    output logic is_mem_o,
    output logic [1:0] disp_n_o
);
    logic [2:0] fld [2];
    aod_pkg::aod_reg_t sel [2];

    assign fld[0] = modrm_i[5:3];
    assign fld[1] = modrm_i[2:0];

    // Byte selects fold onto the low word registers, high half picked by the top bit
    for (genvar g = 0; g < 2; g++) begin : g_sel
        assign sel[g].word = word_i;
        assign sel[g].idx = word_i ? fld[g] : {1'b0, fld[g][1:0]};
        assign sel[g].high = ~word_i & fld[g][2];
    end

    assign reg_sel_o = sel[0];
    assign rm_sel_o = sel[1];
    assign is_mem_o = (modrm_i[7:6] != aod_pkg::MOD_REG);
    assign disp_n_o = (modrm_i[7:6] == aod_pkg::MOD_D8) ? 2'h1 :
        (modrm_i[7:6] == aod_pkg::MOD_D16) ? 2'h2 :
        (modrm_i[7:6] == aod_pkg::MOD_NODISP && modrm_i[2:0] == aod_pkg::RM_DIRECT) ? 2'h2 : 2'h0;
endmodule // aod_field_map

// ---- rtl/aod_decoder.sv ----
// Arithmetic opcode decoder: prefixes, carry/borrow arithmetic, adjusts and multiply
// Operation
// - Bytes 2e, 36, 3e, 26 are segment override prefixes costing two clocks each, counted up to six clocks in total.
// - Add with carry decodes from 000100dw, 100000sw reg 010, 0001010w.
// - Subtract with borrow decodes from 000110dw, 100000sw reg 011, 0001110w.
// - Sign change decodes from 1111011w reg 011; three clocks register, ten memory.
// - Byte 37 is the ASCII fix after addition.
// - Byte 27 is the decimal fix after addition.
// - Byte 3f is the ASCII fix after subtraction.
// - Byte 2f is the decimal fix after subtraction, four clocks.
// - Unsigned multiply decodes from 1111011w reg 100 with its clock ranges.
// - Word memory accesses add four clocks to the byte count, except multiply, which takes its own word memory range.
// - Register field picks word registers, or low then high bytes when narrow.
// - Mode 01 takes one displacement byte sign-extended to sixteen bits.
`timescale 1ns/1ps
module aod_decoder (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction bytes from prefetch
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    // Decoded operation
    output logic op_valid_o,
    output aod_pkg::aod_op_t op_o,
    output logic unsup_o
);
    aod_pkg::aod_core_t q;
    aod_pkg::aod_core_t d;
    aod_pkg::aod_reg_t fm_reg;
    aod_pkg::aod_reg_t fm_rm;
    logic fm_mem;
    logic [1:0] fm_dn;
    logic emit;
    logic drop;
    logic [1:0] pfx_seg_in;

    aod_field_map u_field_map (
        .modrm_i(byte_i),
        .word_i(q.w.word),
        .reg_sel_o(fm_reg),
        .rm_sel_o(fm_rm),
        .is_mem_o(fm_mem),
        .disp_n_o(fm_dn)
    );

    assign pfx_seg_in = byte_i[4:3];

    function automatic aod_pkg::aod_state_t after_disp(input logic [1:0] imm_n);
        after_disp = (imm_n != 2'h0) ? aod_pkg::st_imm_lo : aod_pkg::st_opc;
    endfunction

    // Clock cost is worked out once at emission so every form shares one table
    function automatic logic [13:0] cost(input aod_pkg::aod_op_t o);
        logic [6:0] mn;
        logic [6:0] mx;
        logic [6:0] extra;
        mn = 7'h00;
        mx = 7'h00;
        extra = (o.is_mem && o.word) ? aod_pkg::C_WORD_MEM : 7'h00;
        unique case (o.kind)
            aod_pkg::add_with_carry, aod_pkg::sub_with_borrow_op: begin
                if (o.form == aod_pkg::form_acc) begin
                    mn = o.word ? aod_pkg::C_ACC_W : aod_pkg::C_ACC_B;
                end else if (o.form == aod_pkg::form_imm) begin
                    mn = o.is_mem ? aod_pkg::C_IMM_MEM + extra : aod_pkg::C_IMM_REG;
                end else begin
                    mn = o.is_mem ? aod_pkg::C_RM_MEM + extra : aod_pkg::C_RM_REG;
                end
            end
            aod_pkg::sign_change_op: mn = o.is_mem ? aod_pkg::C_NEG_MEM + extra : aod_pkg::C_NEG_REG;
            aod_pkg::ascii_fix_after_add: mn = aod_pkg::C_AAA;
            aod_pkg::decimal_fix_after_add: mn = aod_pkg::C_DAA;
            aod_pkg::ascii_fix_after_sub: mn = aod_pkg::C_AAS;
            aod_pkg::decimal_fix_after_sub: mn = aod_pkg::C_DAS;
            aod_pkg::unsigned_multiply_op: mn = 7'h00;
            default: mn = 7'h00;
        endcase
        mx = mn;
        // Multiply figures already include the word memory penalty
        if (o.kind == aod_pkg::unsigned_multiply_op) begin
            unique case ({o.is_mem, o.word})
                2'h0: begin mn = aod_pkg::C_MUL_RB_MIN; mx = aod_pkg::C_MUL_RB_MAX; end
                2'h1: begin mn = aod_pkg::C_MUL_RW_MIN; mx = aod_pkg::C_MUL_RW_MAX; end
                2'h2: begin mn = aod_pkg::C_MUL_MB_MIN; mx = aod_pkg::C_MUL_MB_MAX; end
                2'h3: begin mn = aod_pkg::C_MUL_MW_MIN; mx = aod_pkg::C_MUL_MW_MAX; end
            endcase
        end
        cost = {mn, mx};
    endfunction

    always_comb begin
        d = q;
        d.op_valid = 1'b0;
        d.unsup = 1'b0;
        emit = 1'b0;
        drop = 1'b0;
        if (byte_valid_i) begin
            unique case (q.st)
                aod_pkg::st_opc: begin
                    d.w = '0;
                    d.w.seg_ovr_valid = q.w.seg_ovr_valid;
                    d.w.seg = q.w.seg;
                    d.w.pfx_clocks = q.w.pfx_clocks;
                    d.w.word = byte_i[0];
                    d.w.dir_to_reg = byte_i[1];
                    d.w.sx = byte_i[1];
                    if ((byte_i & aod_pkg::PFX_MASK) == aod_pkg::PFX_VAL) begin
                        d.w.seg_ovr_valid = 1'b1;
                        d.w.seg = aod_pkg::aod_seg_t'(byte_i[4:3]);
                        if (q.w.pfx_clocks <= aod_pkg::PFX_CAP) begin
                            d.w.pfx_clocks = q.w.pfx_clocks + aod_pkg::PFX_CLOCKS;
                        end
                    end else if ((byte_i & aod_pkg::RM_MASK) == aod_pkg::ADC_RM) begin
                        d.w.kind = aod_pkg::add_with_carry;
                        d.w.form = aod_pkg::form_rm;
                        d.st = aod_pkg::st_modrm;
                    end else if ((byte_i & aod_pkg::RM_MASK) == aod_pkg::SBB_RM) begin
                        d.w.kind = aod_pkg::sub_with_borrow_op;
                        d.w.form = aod_pkg::form_rm;
                        d.st = aod_pkg::st_modrm;
                    end else if ((byte_i & aod_pkg::RM_MASK) == aod_pkg::GRP_IMM) begin
                        d.w.form = aod_pkg::form_imm;
                        d.st = aod_pkg::st_modrm;
                    end else if ((byte_i & aod_pkg::W_MASK) == aod_pkg::GRP_UNARY) begin
                        d.w.form = aod_pkg::form_unary;
                        d.st = aod_pkg::st_modrm;
                    end else if ((byte_i & aod_pkg::W_MASK) == aod_pkg::ADC_ACC ||
                                 (byte_i & aod_pkg::W_MASK) == aod_pkg::SBB_ACC) begin
                        d.w.kind = ((byte_i & aod_pkg::W_MASK) == aod_pkg::ADC_ACC) ?
                            aod_pkg::add_with_carry : aod_pkg::sub_with_borrow_op;
                        d.w.form = aod_pkg::form_acc;
                        d.imm_n = byte_i[0] ? 2'h2 : 2'h1;
                        d.st = aod_pkg::st_imm_lo;
                    end else if (byte_i == aod_pkg::OPC_AAA) begin
                        d.w.kind = aod_pkg::ascii_fix_after_add;
                        emit = 1'b1;
                    end else if (byte_i == aod_pkg::OPC_DAA) begin
                        d.w.kind = aod_pkg::decimal_fix_after_add;
                        emit = 1'b1;
                    end else if (byte_i == aod_pkg::OPC_AAS) begin
                        d.w.kind = aod_pkg::ascii_fix_after_sub;
                        emit = 1'b1;
                    end else if (byte_i == aod_pkg::OPC_DAS) begin
                        d.w.kind = aod_pkg::decimal_fix_after_sub;
                        emit = 1'b1;
                    end else begin
                        drop = 1'b1;
                    end
                end
                aod_pkg::st_modrm: begin
                    d.w.mode = byte_i[7:6];
                    d.w.reg_fld = byte_i[5:3];
                    d.w.rm_fld = byte_i[2:0];
                    d.w.reg_sel = fm_reg;
                    d.w.rm_sel = fm_rm;
                    d.w.is_mem = fm_mem;
                    d.disp_n = fm_dn;
                    d.imm_n = 2'h0;
                    if (q.w.form == aod_pkg::form_imm) begin
                        d.w.dir_to_reg = 1'b0;
                        d.imm_n = (q.w.word && !q.w.sx) ? 2'h2 : 2'h1;
                        if (byte_i[5:3] == aod_pkg::REG_ADC) begin
                            d.w.kind = aod_pkg::add_with_carry;
                        end else if (byte_i[5:3] == aod_pkg::REG_SBB) begin
                            d.w.kind = aod_pkg::sub_with_borrow_op;
                        end else begin
                            drop = 1'b1;
                        end
                    end else if (q.w.form == aod_pkg::form_unary) begin
                        d.w.dir_to_reg = 1'b0;
                        if (byte_i[5:3] == aod_pkg::REG_NEG) begin
                            d.w.kind = aod_pkg::sign_change_op;
                        end else if (byte_i[5:3] == aod_pkg::REG_MUL) begin
                            d.w.kind = aod_pkg::unsigned_multiply_op;
                        end else begin
                            drop = 1'b1;
                        end
                    end
                    d.st = (fm_dn != 2'h0) ? aod_pkg::st_disp_lo : after_disp(d.imm_n);
                    emit = (d.st == aod_pkg::st_opc);
                end
                aod_pkg::st_disp_lo: begin
                    d.w.disp = (q.w.mode == aod_pkg::MOD_D8) ? {{8{byte_i[7]}}, byte_i} : {8'h00, byte_i};
                    d.st = (q.disp_n == 2'h2) ? aod_pkg::st_disp_hi : after_disp(q.imm_n);
                    emit = (d.st == aod_pkg::st_opc);
                end
                aod_pkg::st_disp_hi: begin
                    d.w.disp[15:8] = byte_i;
                    d.st = after_disp(q.imm_n);
                    emit = (d.st == aod_pkg::st_opc);
                end
                aod_pkg::st_imm_lo: begin
                    d.w.imm = (q.w.form == aod_pkg::form_imm && q.w.sx && q.w.word) ?
                        {{8{byte_i[7]}}, byte_i} : {8'h00, byte_i};
                    d.st = (q.imm_n == 2'h2) ? aod_pkg::st_imm_hi : aod_pkg::st_opc;
                    emit = (d.st == aod_pkg::st_opc);
                end
                aod_pkg::st_imm_hi: begin
                    d.w.imm[15:8] = byte_i;
                    d.st = aod_pkg::st_opc;
                    emit = 1'b1;
                end
            endcase
        end
        // An unknown opcode also discards any pending override
        if (drop) begin
            d.unsup = 1'b1;
            d.st = aod_pkg::st_opc;
            d.w = '0;
        end else if (emit) begin
            d.o = d.w;
            {d.o.clk_min, d.o.clk_max} = cost(d.w);
            d.op_valid = 1'b1;
            d.w.seg_ovr_valid = 1'b0;
            d.w.pfx_clocks = 3'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign op_valid_o = q.op_valid;
    assign op_o = q.o;
    assign unsup_o = q.unsup;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_opc(logic [7:0] v);
        byte_valid_i && q.st == aod_pkg::st_opc && byte_i == v;
    endsequence
    sequence s_sbb_reg;
        byte_valid_i && q.st == aod_pkg::st_opc && (byte_i & aod_pkg::RM_MASK) == aod_pkg::SBB_RM
        ##1 byte_valid_i && byte_i[7:6] == aod_pkg::MOD_REG;
    endsequence
    sequence s_d8_rm;
        byte_valid_i && q.st == aod_pkg::st_modrm && q.w.form == aod_pkg::form_rm && byte_i[7:6] == aod_pkg::MOD_D8
        ##1 byte_valid_i;
    endsequence

    chk_pfx_seg: assert property (byte_valid_i && q.st == aod_pkg::st_opc &&
        (byte_i & aod_pkg::PFX_MASK) == aod_pkg::PFX_VAL |=> q.w.seg_ovr_valid && q.w.seg == $past(pfx_seg_in))
        else $error("override prefix not recorded");
    chk_adc_acc_byte: assert property (s_opc(aod_pkg::ADC_ACC) ##1 byte_valid_i |=>
        op_valid_o && op_o.kind == aod_pkg::add_with_carry && op_o.clk_min == aod_pkg::C_ACC_B)
        else $error("accumulator add with carry wrong");
    chk_sbb_reg_form: assert property (s_sbb_reg |=>
        op_valid_o && op_o.kind == aod_pkg::sub_with_borrow_op && !op_o.is_mem && op_o.clk_min == aod_pkg::C_RM_REG)
        else $error("register subtract with borrow wrong");
    chk_neg_clocks: assert property (op_valid_o && op_o.kind == aod_pkg::sign_change_op && !op_o.is_mem |->
        op_o.clk_min == aod_pkg::C_NEG_REG && op_o.reg_fld == aod_pkg::REG_NEG)
        else $error("sign change cost wrong");
    chk_aaa_decode: assert property (s_opc(aod_pkg::OPC_AAA) |=>
        op_valid_o && op_o.kind == aod_pkg::ascii_fix_after_add) else $error("ascii add fix missed");
    chk_daa_decode: assert property (s_opc(aod_pkg::OPC_DAA) |=>
        op_valid_o && op_o.kind == aod_pkg::decimal_fix_after_add) else $error("decimal add fix missed");
    chk_aas_decode: assert property (s_opc(aod_pkg::OPC_AAS) |=>
        op_valid_o && op_o.kind == aod_pkg::ascii_fix_after_sub) else $error("ascii sub fix missed");
    chk_das_decode: assert property (s_opc(aod_pkg::OPC_DAS) |=>
        op_valid_o && op_o.kind == aod_pkg::decimal_fix_after_sub && op_o.clk_min == aod_pkg::C_DAS)
        else $error("decimal sub fix wrong");
    chk_mul_range: assert property (op_valid_o && op_o.kind == aod_pkg::unsigned_multiply_op && op_o.word |->
        op_o.clk_min == (op_o.is_mem ? aod_pkg::C_MUL_MW_MIN : aod_pkg::C_MUL_RW_MIN) &&
        op_o.clk_max == (op_o.is_mem ? aod_pkg::C_MUL_MW_MAX : aod_pkg::C_MUL_RW_MAX))
        else $error("multiply clock range wrong");
    chk_word_mem_add: assert property (op_valid_o && op_o.kind == aod_pkg::add_with_carry &&
        op_o.form == aod_pkg::form_rm && op_o.is_mem |->
        op_o.clk_min == aod_pkg::C_RM_MEM + (op_o.word ? aod_pkg::C_WORD_MEM : 7'h00))
        else $error("word memory penalty wrong");
    chk_reg_select: assert property (op_valid_o && op_o.form != aod_pkg::form_acc &&
        op_o.form != aod_pkg::form_none |-> (op_o.reg_sel.word ? op_o.reg_sel.idx == op_o.reg_fld :
        {op_o.reg_sel.high, op_o.reg_sel.idx[1:0]} == op_o.reg_fld && !op_o.reg_sel.idx[2]))
        else $error("register select wrong");
    chk_disp_sext: assert property (s_d8_rm |=>
        op_valid_o && op_o.disp == {{8{$past(byte_i[7])}}, $past(byte_i)})
        else $error("short displacement not sign extended");
    chk_imm_sext: assert property (op_valid_o && op_o.form == aod_pkg::form_imm && op_o.sx && op_o.word |->
        op_o.imm[15:8] == {8{op_o.imm[7]}} && !op_o.dir_to_reg)
        else $error("immediate byte not sign extended");
endmodule // aod_decoder

// ---- dv/tb_top.sv ----
// Self-checking testbench for the arithmetic opcode decoder
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic byte_valid_i = 1'b0;
    logic [7:0] byte_i = 8'h00;
    logic op_valid_o;
    logic unsup_o;
    aod_pkg::aod_op_t op_o;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;

    aod_decoder dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .byte_valid_i(byte_valid_i),
        .byte_i(byte_i),
        .op_valid_o(op_valid_o),
        .op_o(op_o),
        .unsup_o(unsup_o)
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // All runs are short; a hang means the stream handling is stuck
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bytes go out back to back at falling edges; the answer is sampled one cycle after the last byte
    task automatic send(input logic [39:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            byte_valid_i = 1'b1;
            byte_i = b[8*(n-1-i) +: 8];
        end
        @(negedge clk_i);
        byte_valid_i = 1'b0;
    endtask

    task automatic run(input logic [39:0] b, input int n, input aod_pkg::aod_kind_t k,
                       input logic [6:0] cmin, input logic [6:0] cmax);
        send(b, n);
        chk("op_valid", 16'(op_valid_o), 16'h0001);
        chk("unsup", 16'(unsup_o), 16'h0000);
        chk("kind", 16'(op_o.kind), 16'(k));
        chk("clk_min", 16'(op_o.clk_min), 16'(cmin));
        chk("clk_max", 16'(op_o.clk_max), 16'(cmax));
    endtask

    task automatic t_prefix();
        logic [7:0] pb[4] = '{8'h2e, 8'h36, 8'h3e, 8'h26};
        aod_pkg::aod_seg_t sg[4] = '{aod_pkg::code_segment, aod_pkg::stack_segment, aod_pkg::data_segment,
                                     aod_pkg::extra_segment};
        for (int i = 0; i < 4; i++) begin
            run({24'h0, pb[i], 8'h37}, 2, aod_pkg::ascii_fix_after_add, 7'h08, 7'h08);
            chk("seg", 16'(op_o.seg), 16'(sg[i]));
            chk("seg_ovr", 16'(op_o.seg_ovr_valid), 16'h0001);
            chk("pfx_clocks", 16'(op_o.pfx_clocks), 16'h0002);
        end
        run(40'h263e37, 3, aod_pkg::ascii_fix_after_add, 7'h08, 7'h08);
        chk("pfx_clocks", 16'(op_o.pfx_clocks), 16'h0004);
        send(40'h2e90, 2);
        chk("unsup", 16'(unsup_o), 16'h0001);
        run(40'h37, 1, aod_pkg::ascii_fix_after_add, 7'h08, 7'h08);
        chk("seg_ovr", 16'(op_o.seg_ovr_valid), 16'h0000);
        $display("prefix test done");
    endtask

    task automatic t_adjust();
        run(40'h37, 1, aod_pkg::ascii_fix_after_add, 7'h08, 7'h08);
        run(40'h27, 1, aod_pkg::decimal_fix_after_add, 7'h07, 7'h07);
        run(40'h3f, 1, aod_pkg::ascii_fix_after_sub, 7'h07, 7'h07);
        run(40'h2f, 1, aod_pkg::decimal_fix_after_sub, 7'h04, 7'h04);
        $display("adjust test done");
    endtask

    task automatic t_rm();
        run(40'h11c8, 2, aod_pkg::add_with_carry, 7'h03, 7'h03);
        chk("reg_sel", 16'(op_o.reg_sel), 16'h0012);
        chk("rm_sel", 16'(op_o.rm_sel), 16'h0010);
        chk("dir", 16'(op_o.dir_to_reg), 16'h0000);
        run(40'h1b07, 2, aod_pkg::sub_with_borrow_op, 7'h0e, 7'h0e);
        chk("dir", 16'(op_o.dir_to_reg), 16'h0001);
        run(40'h1bc1, 2, aod_pkg::sub_with_borrow_op, 7'h03, 7'h03);
        chk("is_mem", 16'(op_o.is_mem), 16'h0000);
        run(40'h1a6680, 3, aod_pkg::sub_with_borrow_op, 7'h0a, 7'h0a);
        chk("reg_sel", 16'(op_o.reg_sel), 16'h0001);
        chk("disp", op_o.disp, 16'hff80);
        // Two-byte displacement with a word operand exercises the memory penalty on the register form
        run(40'h11963412, 4, aod_pkg::add_with_carry, 7'h0e, 7'h0e);
        chk("disp", op_o.disp, 16'h1234);
        $display("register form test done");
    endtask

    task automatic t_imm();
        run(40'h3e8356fc05, 5, aod_pkg::add_with_carry, 7'h14, 7'h14);
        chk("seg", 16'(op_o.seg), 16'(aod_pkg::data_segment));
        chk("disp", op_o.disp, 16'hfffc);
        chk("imm", op_o.imm, 16'h0005);
        run(40'h81d83412, 4, aod_pkg::sub_with_borrow_op, 7'h04, 7'h04);
        chk("imm", op_o.imm, 16'h1234);
        run(40'h83d080, 3, aod_pkg::add_with_carry, 7'h04, 7'h04);
        chk("imm", op_o.imm, 16'hff80);
        run(40'h80d87f, 3, aod_pkg::sub_with_borrow_op, 7'h04, 7'h04);
        chk("imm", op_o.imm, 16'h007f);
        $display("immediate group test done");
    endtask

    task automatic t_acc();
        run(40'h153412, 3, aod_pkg::add_with_carry, 7'h04, 7'h04);
        chk("imm", op_o.imm, 16'h1234);
        run(40'h14ff, 2, aod_pkg::add_with_carry, 7'h03, 7'h03);
        chk("imm", op_o.imm, 16'h00ff);
        run(40'h1c80, 2, aod_pkg::sub_with_borrow_op, 7'h03, 7'h03);
        chk("imm", op_o.imm, 16'h0080);
        run(40'h1d0180, 3, aod_pkg::sub_with_borrow_op, 7'h04, 7'h04);
        chk("imm", op_o.imm, 16'h8001);
        $display("accumulator test done");
    endtask

    task automatic t_unary();
        run(40'hf7d8, 2, aod_pkg::sign_change_op, 7'h03, 7'h03);
        run(40'hf618, 2, aod_pkg::sign_change_op, 7'h0a, 7'h0a);
        run(40'hf718, 2, aod_pkg::sign_change_op, 7'h0e, 7'h0e);
        run(40'hf6e4, 2, aod_pkg::unsigned_multiply_op, 7'h1a, 7'h1c);
        chk("rm_sel", 16'(op_o.rm_sel), 16'h0001);
        run(40'hf7e1, 2, aod_pkg::unsigned_multiply_op, 7'h23, 7'h25);
        chk("rm_sel", 16'(op_o.rm_sel), 16'h0012);
        run(40'hf720, 2, aod_pkg::unsigned_multiply_op, 7'h29, 7'h2b);
        run(40'hf6263412, 4, aod_pkg::unsigned_multiply_op, 7'h20, 7'h22);
        chk("disp", op_o.disp, 16'h1234);
        $display("unary group test done");
    endtask

    task automatic t_unsup();
        logic [15:0] bad[3] = '{16'h0090, 16'h80c0, 16'hf600};
        for (int i = 0; i < 3; i++) begin
            send({24'h0, bad[i]}, (i == 0) ? 1 : 2);
            chk("unsup", 16'(unsup_o), 16'h0001);
            chk("op_valid", 16'(op_valid_o), 16'h0000);
        end
        $display("unsupported test done");
    endtask

    // Reset in mid-run must clear the outputs and drop a prefix that was still pending
    task automatic t_reset();
        run(40'h37, 1, aod_pkg::ascii_fix_after_add, 7'h08, 7'h08);
        send(40'h2e, 1);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("op_valid", 16'(op_valid_o), 16'h0000);
        chk("unsup", 16'(unsup_o), 16'h0000);
        chk("kind", 16'(op_o.kind), 16'(aod_pkg::op_none));
        rst_i = 1'b0;
        run(40'h37, 1, aod_pkg::ascii_fix_after_add, 7'h08, 7'h08);
        chk("seg_ovr", 16'(op_o.seg_ovr_valid), 16'h0000);
        $display("reset test done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        t_prefix();
        t_adjust();
        t_rm();
        t_imm();
        t_acc();
        t_unary();
        t_unsup();
        t_reset();
        close_out();
    end
endmodule // tb_top
